//--- logic/spi_port.sv
// Purpose: Master/slave serial peripheral port exchanging 8-bit characters.
// Assumes: Pins are synchronous inputs; output enable high means the pin is driven.
// Notes: Status read then data access clears the complete and collision flags; status read then control write clears mode fault; no interrupt logic.
`timescale 1ns/1ps
module spi_port (
    input wire logic mclk, // Bus clock.
    input wire logic rst_b, // Synchronous reset, active low.
    input wire spi_port_pkg::spi_cfg_t cfg, // Control bits.
    input wire spi_port_pkg::pin4_t dir, // Port direction register bits.
    input wire spi_port_pkg::pin4_t gpio_out, // General-purpose output levels.
    input wire spi_port_pkg::pin4_t pin_in, // Pin levels seen at the pads.
    input wire logic data_wr, // Write strobe of the data register.
    input wire logic [7:0] data_wdata, // Write data of the data register.
    input wire logic data_rd, // Read strobe of the data register.
    input wire logic status_rd, // Read strobe of the status register.
    input wire logic ctrl_wr, // Write strobe of the control register.
    output spi_port_pkg::pin4_t pin_out, // Pin output levels.
    output spi_port_pkg::pin4_t pin_oe, // Pin output enables.
    output logic [7:0] read_data, // Read buffer contents.
    output logic transfer_complete_flag, // Transfer complete flag.
    output logic write_collision, // Write collision flag.
    output logic mode_fault, // Mode fault flag.
    output logic busy, // Transfer in progress.
    output logic fault_clear_dirs // Pulse: software must clear master and SPI directions.
);

    typedef enum logic [1:0] {IDLE, RUN, DONE} state_t;

    // Half-period length for a rate code.
    function automatic logic [4:0] half_len(input logic [1:0] code);
        case (code)
            2'h0: half_len = spi_port_pkg::HALF_DIV2;
            2'h1: half_len = spi_port_pkg::HALF_DIV4;
            2'h2: half_len = spi_port_pkg::HALF_DIV16;
            default: half_len = spi_port_pkg::HALF_DIV32;
        endcase
    endfunction : half_len

    state_t state, next_state;
    logic [7:0] shifter, next_shifter;
    logic [7:0] rbuf, next_rbuf;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [4:0] div_cnt, next_div_cnt;
    logic sck_int, next_sck_int;
    logic in_bit, next_in_bit;
    logic sck_prev, next_sck_prev;
    logic sel_prev, next_sel_prev;
    logic flag_tc, next_flag_tc;
    logic flag_wc, next_flag_wc;
    logic flag_mf, next_flag_mf;
    logic armed, next_armed;
    logic mf_pulse, next_mf_pulse;
    logic out_q, next_out_q;
    spi_port_pkg::pin4_t next_pin_out, next_pin_oe;

    logic is_master, is_slave, slave_sel, sck_lead, sck_trail, tick, sel_fall;
    logic fault_now, serial_in, out_bit;

    assign is_master = cfg.enable && cfg.master && !flag_mf;
    assign is_slave = cfg.enable && !cfg.master;
    assign slave_sel = is_slave && !pin_in.sel;
    assign fault_now = cfg.enable && cfg.master && !dir.sel && !pin_in.sel;
    assign serial_in = cfg.master ? pin_in.miso : pin_in.mosi;
    // Leading and trailing edges of the slave clock relative to idle polarity.
    assign sck_lead = (pin_in.sck != cfg.cpol) && (sck_prev == cfg.cpol);
    assign sck_trail = (pin_in.sck == cfg.cpol) && (sck_prev != cfg.cpol);
    assign sel_fall = sel_prev && !pin_in.sel;
    assign tick = (div_cnt == 5'h01);
    assign out_bit = shifter[7];

    // Transfer sequencing, shifting, buffering and flags.
    always_comb
    begin
        next_state = state;
        next_shifter = shifter;
        next_rbuf = rbuf;
        next_bit_cnt = bit_cnt;
        next_div_cnt = div_cnt;
        next_sck_int = sck_int;
        next_in_bit = in_bit;
        next_sck_prev = pin_in.sck;
        next_sel_prev = pin_in.sel;
        next_flag_tc = flag_tc;
        next_flag_wc = flag_wc;
        next_flag_mf = flag_mf;
        next_armed = armed;
        next_mf_pulse = 1'b0;
        next_out_q = out_q;
        // Flag clears: a status read arms, a later data or control access clears.
        if (status_rd)
        begin
            next_armed = flag_tc || flag_wc || flag_mf;
        end
        if (armed && (data_rd || data_wr))
        begin
            next_flag_tc = 1'b0;
            next_flag_wc = 1'b0;
            next_armed = 1'b0;
        end
        if (armed && ctrl_wr)
        begin
            next_flag_mf = 1'b0;
            next_armed = 1'b0;
        end
        // Data writes load the shifter only between transfers.
        if (data_wr)
        begin
            if (state == RUN || (slave_sel && !cfg.cpha))
            begin
                next_flag_wc = 1'b1;
            end
            else
            begin
                next_shifter = data_wdata;
                if (is_master)
                begin
                    next_state = RUN;
                    next_bit_cnt = 4'h0;
                    next_sck_int = 1'b0;
                    next_div_cnt = half_len(cfg.rate);
                end
            end
        end
        case (state)
            IDLE:
            begin
                // Slave begins at the first leading edge while selected.
                if (slave_sel && sck_lead)
                begin
                    next_state = RUN;
                    next_bit_cnt = 4'h0;
                    next_in_bit = serial_in;
                end
                if (slave_sel && sel_fall)
                begin
                    next_bit_cnt = 4'h0;
                end
            end
            RUN:
            begin
                if (is_master)
                begin
                    next_div_cnt = tick ? half_len(cfg.rate) : 5'(div_cnt - 5'h01);
                    if (tick)
                    begin
                        next_sck_int = !sck_int;
                        if (!sck_int)
                        begin
                            // Phase one changes data on the leading edge, phase zero samples there.
                            if (cfg.cpha)
                            begin
                                next_out_q = shifter[7];
                                next_shifter = {shifter[6:0], 1'b0};
                            end
                            else
                            begin
                                next_in_bit = serial_in;
                            end
                        end
                        else
                        begin
                            // Phase one samples on the trailing edge into the freed low bit.
                            next_shifter = cfg.cpha ? {shifter[7:1], serial_in} : {shifter[6:0], in_bit};
                            next_bit_cnt = 4'(bit_cnt + 4'h1);
                            if (4'(bit_cnt + 4'h1) == spi_port_pkg::BITS_PER_CHAR)
                            begin
                                next_state = DONE;
                            end
                        end
                    end
                end
                else if (slave_sel)
                begin
                    if (sck_lead)
                    begin
                        next_in_bit = serial_in;
                    end
                    if (sck_trail)
                    begin
                        next_shifter = {shifter[6:0], in_bit};
                        next_bit_cnt = 4'(bit_cnt + 4'h1);
                        if (4'(bit_cnt + 4'h1) == spi_port_pkg::BITS_PER_CHAR)
                        begin
                            next_state = DONE;
                        end
                    end
                end
                else if (!is_slave || !cfg.enable)
                begin
                    next_state = IDLE;
                    next_sck_int = 1'b0;
                end
            end
            DONE:
            begin
                next_rbuf = shifter;
                next_flag_tc = 1'b1;
                next_state = IDLE;
            end
            default:
            begin
                next_state = IDLE;
            end
        endcase
        // Mode fault stops the transfer at once; the pins are released one cycle after the flag sets.
        if (fault_now)
        begin
            next_flag_mf = 1'b1;
            next_mf_pulse = !flag_mf;
            next_state = IDLE;
            next_sck_int = 1'b0;
        end
    end

    // Pin drive: general I/O when disabled, serial roles when enabled.
    always_comb
    begin
        next_pin_out = gpio_out;
        next_pin_oe = dir;
        if (cfg.enable)
        begin
            if (is_master)
            begin
                // Launched from the next values so the pin edge lands in the cycle of the sample.
                next_pin_out.sck = next_sck_int ^ cfg.cpol;
                next_pin_out.mosi = cfg.cpha ? next_out_q : next_shifter[7];
                next_pin_oe.miso = 1'b0;
                next_pin_oe.sel = dir.sel;
            end
            else if (cfg.master)
            begin
                // Faulted master: every serial pin released.
                next_pin_oe = '0;
            end
            else
            begin
                next_pin_out.miso = out_bit;
                next_pin_oe.sck = 1'b0;
                next_pin_oe.mosi = 1'b0;
                next_pin_oe.sel = 1'b0;
                next_pin_oe.miso = dir.miso && !pin_in.sel;
            end
        end
        // Open drain: a high level is left to the external pull-up.
        if (cfg.open_drain)
        begin
            next_pin_oe = next_pin_oe & ~next_pin_out;
            next_pin_out = '0;
        end
    end

    // State registers.
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            state <= IDLE;
            shifter <= spi_port_pkg::DATA_RESET;
            rbuf <= spi_port_pkg::DATA_RESET;
            bit_cnt <= 4'h0;
            div_cnt <= 5'h01;
            sck_int <= 1'b0;
            in_bit <= 1'b0;
            sck_prev <= 1'b0;
            sel_prev <= 1'b1;
            flag_tc <= 1'b0;
            flag_wc <= 1'b0;
            flag_mf <= 1'b0;
            armed <= 1'b0;
            mf_pulse <= 1'b0;
            out_q <= 1'b0;
            pin_out <= '0;
            pin_oe <= '0;
        end
        else
        begin
            state <= next_state;
            shifter <= next_shifter;
            rbuf <= next_rbuf;
            bit_cnt <= next_bit_cnt;
            div_cnt <= next_div_cnt;
            sck_int <= next_sck_int;
            in_bit <= next_in_bit;
            sck_prev <= next_sck_prev;
            sel_prev <= next_sel_prev;
            flag_tc <= next_flag_tc;
            flag_wc <= next_flag_wc;
            flag_mf <= next_flag_mf;
            armed <= next_armed;
            mf_pulse <= next_mf_pulse;
            out_q <= next_out_q;
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
        end
    end

    assign read_data = rbuf;
    assign transfer_complete_flag = flag_tc;
    assign write_collision = flag_wc;
    assign mode_fault = flag_mf;
    assign busy = (state != IDLE);
    assign fault_clear_dirs = mf_pulse;

    // Helper: serial clock edges counted during a master transfer.
    logic [4:0] sck_edges;
    always_ff @(posedge mclk)
    begin
        if (!rst_b || (state == IDLE && next_state == RUN))
        begin
            sck_edges <= 5'h00;
        end
        else if (state == RUN && is_master && tick)
        begin
            sck_edges <= 5'(sck_edges + 5'h01);
        end
    end

    sequence seq_done;
        state == DONE;
    endsequence

    AST_EIGHT_CYCLES: assert property (@(posedge mclk) disable iff (!rst_b)
        (state == RUN && next_state == DONE && is_master) |-> sck_edges == 5'h0f)
        else $error("Master transfer did not make eight clock cycles.");
    AST_BUFFER_COPY: assert property (@(posedge mclk) disable iff (!rst_b)
        seq_done |=> (rbuf == $past(shifter)) && flag_tc)
        else $error("Read buffer or flag not updated at completion.");
    AST_WCOL_SEL: assert property (@(posedge mclk) disable iff (!rst_b)
        (data_wr && slave_sel && !cfg.cpha) |=> flag_wc)
        else $error("Phase zero slave write with select low missed collision.");
    AST_SINGLE_BUF: assert property (@(posedge mclk) disable iff (!rst_b)
        (data_wr && state == RUN && !fault_now) |=> flag_wc)
        else $error("Write during transfer was not refused.");
    AST_FAULT_RELEASE: assert property (@(posedge mclk) disable iff (!rst_b)
        fault_now |=> flag_mf ##1 (pin_oe == '0 || cfg.master == 1'b0 || !cfg.enable))
        else $error("Mode fault did not release the serial pins.");
    AST_DESEL_MISO: assert property (@(posedge mclk) disable iff (!rst_b)
        (is_slave && pin_in.sel) |=> !pin_oe.miso)
        else $error("Deselected slave drove its data output.");
    AST_SLAVE_INPUTS: assert property (@(posedge mclk) disable iff (!rst_b)
        (is_slave && $stable(cfg)) |=> (!pin_oe.sck && !pin_oe.mosi && !pin_oe.sel))
        else $error("Slave drove a pin it uses as input.");
    AST_OPEN_DRAIN: assert property (@(posedge mclk) disable iff (!rst_b)
        $past(cfg.open_drain) |-> pin_out == '0)
        else $error("Open-drain mode drove a high level.");
    AST_IDLE_POL: assert property (@(posedge mclk) disable iff (!rst_b)
        (is_master && state == IDLE && $stable(cfg) && $past(state) == IDLE) |=> pin_out.sck == $past(cfg.cpol)
            || $past(cfg.open_drain))
        else $error("Serial clock not at its idle level.");

endmodule : spi_port

//--- logic/spi_port_pkg.sv
// Purpose: Shared constants and carrier types for the serial peripheral port.
// Assumes: One 200 MHz clock; all pin inputs already synchronous to it.
// Notes: Pin index order is select, clock, master-out, master-in.
package spi_port_pkg;

    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned DATA_BITS = 8;
    localparam int unsigned BIT_CNT_W = 4;
    localparam logic [3:0] BITS_PER_CHAR = 4'h8;

    // Pin indices within the four-bit pin groups.
    localparam int unsigned PIN_SEL = 0;
    localparam int unsigned PIN_SCK = 1;
    localparam int unsigned PIN_MOSI = 2;
    localparam int unsigned PIN_MISO = 3;

    // Half-period of the serial clock in bus clocks, per rate code.
    localparam logic [4:0] HALF_DIV2 = 5'h01;
    localparam logic [4:0] HALF_DIV4 = 5'h02;
    localparam logic [4:0] HALF_DIV16 = 5'h08;
    localparam logic [4:0] HALF_DIV32 = 5'h10;

    localparam logic [7:0] DATA_RESET = 8'h00;

    // Static configuration from the control bits.
    typedef struct packed {
        logic enable;
        logic master;
        logic cpol;
        logic cpha;
        logic [1:0] rate;
        logic open_drain;
    } spi_cfg_t;

    // Four pins: value, enable or level per pin.
    typedef struct packed {
        logic miso;
        logic mosi;
        logic sck;
        logic sel;
    } pin4_t;

endpackage : spi_port_pkg

//--- test/spi_far_end.sv
// Purpose: Far-side model: a slave peripheral when the port is master, a master when it is slave.
// Assumes: Pins resolved by the bench; as master it runs eight bus clocks per clock phase.
// Notes: The slave part reacts at once to clock edges, with no setup margin given.
`timescale 1ns/1ps
module spi_far_end (
    input wire logic mclk, // Bus clock used to pace the master part.
    input wire logic cpol, // Clock polarity.
    input wire logic cpha, // Clock phase.
    input wire logic psel, // Select of the slave part.
    input wire spi_port_pkg::pin4_t line, // Resolved pin levels.
    input wire logic [7:0] tx_byte, // Byte sent by the slave part.
    output spi_port_pkg::pin4_t pout, // Levels driven by this model.
    output spi_port_pkg::pin4_t poe, // Drive enables of this model.
    output logic [7:0] rx_byte // Byte received by the slave part.
);
    logic [8:0] sr = 9'h000;
    logic m_en = 1'b0;
    logic m_sck = 1'b0;
    logic m_mosi = 1'b0;
    logic m_sel = 1'b1;

    // The slave part drives the return line only while selected.
    assign pout = '{miso: sr[8], mosi: m_mosi, sck: m_sck, sel: m_sel};
    assign poe = '{miso: psel, mosi: m_en, sck: m_en, sel: m_en};

    // Load on select; phase one keeps a spare slot so the first edge brings the top bit out.
    always @(posedge psel) sr <= cpha ? {1'b0, tx_byte} : {tx_byte, 1'b0};

    // Sample on one clock edge and shift on the other, top bit first.
    always @(line.sck)
    begin
        if (psel && (cpha ? line.sck == cpol : line.sck != cpol))
            rx_byte <= {rx_byte[6:0], line.mosi};
        else if (psel)
            sr <= {sr[7:0], 1'b0};
    end

    // Master part: one character, the clock standing at idle outside the frame.
    task automatic run_master(input logic [7:0] tx, input logic keep, output logic [7:0] rx);
        rx = 8'h00;
        m_sck <= cpol;
        m_sel <= 1'b0;
        m_mosi <= tx[7];
        repeat (8) @(posedge mclk);
        for (int i = 7; i >= 0; i--)
        begin
            m_sck <= ~cpol;
            if (cpha) m_mosi <= tx[i];
            else rx = {rx[6:0], line.miso};
            repeat (8) @(posedge mclk);
            m_sck <= cpol;
            if (cpha) rx = {rx[6:0], line.miso};
            else if (i > 0) m_mosi <= tx[i-1];
            repeat (8) @(posedge mclk);
        end
        m_sel <= keep ? 1'b0 : 1'b1;
        repeat (8) @(posedge mclk);
    endtask : run_master
endmodule : spi_far_end

//--- test/tb_top.sv
// Purpose: Self-checking bench for the serial port in both roles.
// Assumes: Lines with no driver show a pattern that toggles every cycle, or a high level in open-drain mode.
// Notes: Expected bytes come from a queue filled by the bench.
`timescale 1ns/1ps
module tb_top;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    spi_port_pkg::spi_cfg_t cfg = '0;
    spi_port_pkg::pin4_t dir = '0;
    spi_port_pkg::pin4_t gpio_out = '0;
    spi_port_pkg::pin4_t pin_out, pin_oe, pout, poe, line;
    logic data_wr = 1'b0, data_rd = 1'b0, status_rd = 1'b0, ctrl_wr = 1'b0, psel = 1'b0, flip = 1'b0;
    logic [7:0] data_wdata = 8'h00, ptx = 8'h00, prx, read_data;
    logic transfer_complete_flag, write_collision, mode_fault, busy, fault_clear_dirs;
    int err_count = 0, n_tests = 0, cycles = 0;
    int half_tab[4] = '{1, 2, 8, 16};
    logic [7:0] rd_q[$];

    spi_port spi_port_i (.mclk(mclk), .rst_b(rst_b), .cfg(cfg), .dir(dir), .gpio_out(gpio_out), .pin_in(line),
        .data_wr(data_wr), .data_wdata(data_wdata), .data_rd(data_rd), .status_rd(status_rd), .ctrl_wr(ctrl_wr),
        .pin_out(pin_out), .pin_oe(pin_oe), .read_data(read_data), .transfer_complete_flag(transfer_complete_flag),
        .write_collision(write_collision), .mode_fault(mode_fault), .busy(busy), .fault_clear_dirs(fault_clear_dirs));
    spi_far_end spi_far_end_i (.mclk(mclk), .cpol(cfg.cpol), .cpha(cfg.cpha), .psel(psel), .line(line),
        .tx_byte(ptx), .pout(pout), .poe(poe), .rx_byte(prx));

    // Clock, released-line pattern and hang limit.
    always #2.5 mclk = ~mclk;
    always @(posedge mclk)
    begin
        flip <= ~flip;
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            end_sim();
        end
    end

    // Wire level: the port first, then the model, then pull-up or toggling pattern.
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            line[i] = pin_oe[i] ? pin_out[i] : poe[i] ? pout[i] : cfg.open_drain ? 1'b1 : flip;
    end

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp

    task automatic end_sim();
        if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim

    // Status read then data access; both flags must drop.
    task automatic rd_clear();
        @(posedge mclk);
        status_rd <= 1'b1;
        @(posedge mclk);
        status_rd <= 1'b0;
        data_rd <= 1'b1;
        @(posedge mclk);
        data_rd <= 1'b0;
        @(negedge mclk);
        cmp({6'h0, transfer_complete_flag, write_collision}, 8'h00);
    endtask : rd_clear

    // One master transfer, counting clock pulses and cycles, with an optional write while busy.
    task automatic master_xfer(input logic [7:0] tx, input logic collide);
        int cyc;
        int pulses;
        int exp_cyc;
        logic prev;
        cyc = 0;
        pulses = 0;
        prev = cfg.cpol;
        exp_cyc = 16 * half_tab[cfg.rate] + 2;
        ptx <= 8'($urandom);
        @(posedge mclk);
        psel <= 1'b1;
        rd_q.push_back(ptx);
        data_wr <= 1'b1;
        data_wdata <= tx;
        while (transfer_complete_flag !== 1'b1 && cyc < 1200)
        begin
            @(posedge mclk);
            data_wr <= collide && cyc == 8;
            data_wdata <= ~tx;
            #1;
            cyc++;
            if (line.sck != prev && prev == cfg.cpol) pulses++;
            prev = line.sck;
            if (busy === 1'b1) cmp({4'h0, pin_oe}, 8'h07);
        end
        psel <= 1'b0;
        cmp(8'(pulses), 8'h08);
        cmp({7'h0, line.sck}, {7'h0, cfg.cpol});
        cmp({7'h0, cyc >= exp_cyc - 2 && cyc <= exp_cyc + 2}, 8'h01);
        cmp(read_data, rd_q.pop_front());
        cmp(prx, tx);
        cmp({6'h0, write_collision, mode_fault}, {6'h0, collide, 1'b0});
        rd_clear();
    endtask : master_xfer

    // One slave transfer paced by the far-side master.
    task automatic slave_xfer(input logic keep);
        logic [7:0] stx;
        logic [7:0] got;
        int n;
        stx = 8'($urandom);
        n = 0;
        rd_q.push_back(8'($urandom));
        @(negedge mclk);
        if (line.sel === 1'b1) cmp({7'h0, pin_oe.miso}, 8'h00);
        @(posedge mclk);
        data_wr <= 1'b1;
        data_wdata <= stx;
        @(posedge mclk);
        data_wr <= 1'b0;
        spi_far_end_i.run_master(rd_q[0], keep, got);
        while (transfer_complete_flag !== 1'b1 && n < 64)
        begin
            @(negedge mclk);
            n++;
        end
        cmp(got, stx);
        cmp(read_data, rd_q.pop_front());
        cmp({5'h0, pin_oe.mosi, pin_oe.sck, pin_oe.sel}, 8'h00);
        rd_clear();
    endtask : slave_xfer

    // Main sequence: reset, plain I/O, master, slave, mode fault.
    initial
    begin
        logic pol;
        int n;
        logic seen;
        n = $urandom(85);
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        @(negedge mclk);
        cmp({3'h0, busy, transfer_complete_flag, write_collision, mode_fault, fault_clear_dirs}, 8'h00);
        cmp({4'h0, pin_oe}, 8'h00);
        repeat (6)
        begin
            @(posedge mclk);
            cfg <= spi_port_pkg::spi_cfg_t'(7'($urandom) & 7'h3f);
            dir <= 4'($urandom);
            gpio_out <= 4'($urandom);
            repeat (3) @(posedge mclk);
            @(negedge mclk);
            cmp({4'h0, pin_oe}, {4'h0, cfg.open_drain ? dir & ~gpio_out : dir});
            cmp({4'h0, pin_out & pin_oe}, {4'h0, cfg.open_drain ? 4'h0 : gpio_out & dir});
        end
        for (int k = 0; k < 8; k++)
        begin
            @(posedge mclk);
            cfg <= '{enable: 1'b1, master: 1'b1, cpol: k[2], cpha: 1'($urandom), rate: k[1:0], open_drain: 1'b0};
            dir <= 4'hf;
            gpio_out <= {3'h0, k[0]};
            repeat (3) @(posedge mclk);
            master_xfer(8'($urandom), k == 7);
        end
        for (int p = 0; p < 2; p++)
        begin
            @(posedge mclk);
            pol = 1'($urandom);
            cfg <= '{enable: 1'b1, master: 1'b0, cpol: pol, cpha: p[0], rate: 2'($urandom), open_drain: 1'b0};
            spi_far_end_i.m_sck <= pol;
            spi_far_end_i.m_en <= 1'b1;
            repeat (4) @(posedge mclk);
            slave_xfer(p[0]);
            slave_xfer(1'b0);
        end
        @(posedge mclk);
        cfg.cpha <= 1'b0;
        spi_far_end_i.m_sel <= 1'b0;
        @(posedge mclk);
        data_wr <= 1'b1;
        @(posedge mclk);
        data_wr <= 1'b0;
        spi_far_end_i.m_sel <= 1'b1;
        @(negedge mclk);
        cmp({7'h0, write_collision}, 8'h01);
        rd_clear();
        @(posedge mclk);
        cfg <= '{enable: 1'b1, master: 1'b1, cpol: 1'b0, cpha: 1'b0, rate: 2'h0, open_drain: 1'b0};
        dir <= 4'he;
        repeat (4) @(posedge mclk);
        spi_far_end_i.m_sel <= 1'b0;
        seen = 1'b0;
        for (n = 0; n < 16; n++)
        begin
            @(negedge mclk);
            seen |= fault_clear_dirs;
        end
        cmp({6'h0, mode_fault, seen}, 8'h03);
        cmp({4'h0, pin_oe}, 8'h00);
        @(posedge mclk);
        spi_far_end_i.m_sel <= 1'b1;
        status_rd <= 1'b1;
        @(posedge mclk);
        status_rd <= 1'b0;
        cfg.enable <= 1'b0;
        ctrl_wr <= 1'b1;
        @(posedge mclk);
        ctrl_wr <= 1'b0;
        @(negedge mclk);
        cmp({7'h0, mode_fault}, 8'h00);
        end_sim();
    end
endmodule : tb_top
